//--- src/fault_resp_pkg.sv
// constants for the fault reaction and overvoltage threshold registers
package fault_resp_pkg;
    // command codes
    localparam logic [7:0]  CMD_REACTION  = 8'hD2;
    localparam logic [7:0]  CMD_OV_THRESH = 8'hD3;
    // field layout
    localparam int          FAULT_LO      = 2;
    localparam int          FAULT_HI      = 9;
    localparam int          OV_BIT        = 7;
    localparam logic [15:0] REACTION_USED = 16'h03FF;
    localparam logic [15:0] REACTION_ONES = 16'h03FF;
    localparam logic [15:0] REACTION_ZERO = 16'h0000;
    localparam logic [7:0]  OV_USED       = 8'h07;
    localparam logic [2:0]  OV_RESET      = 3'h6;
    // hiccup timing
    localparam int          CLK_HZ        = 40_000_000;
    localparam int          HICCUP_MS     = 500;
    localparam int          HICCUP_CYC    = HICCUP_MS * (CLK_HZ / 1000);
    // protection state, one-hot
    typedef enum logic [3:0] {
        ST_OFF     = 4'h1,
        ST_RUN     = 4'h2,
        ST_HICCUP  = 4'h4,
        ST_LATCHED = 4'h8
    } prot_state_t;
endpackage : fault_resp_pkg

//--- src/fault_response_ovp_config.sv
// fault reaction select, overvoltage threshold and protection sequencer
`timescale 1ns/100ps

// How it works
// - strap level fills reaction bits 9:0 at reset
// - reaction bit 1 means hiccup, 0 latch-off
// - hiccup stops, waits 500 ms, restarts soft-start
// - latch-off keeps switching off after fault clears
// - command port stays usable while latched off
// - only enable toggle or reset leaves latch-off
// - reaction register 16 bits, bits 15:10 zero
// - reaction bits 2..9 map to eight faults
// - overvoltage when feedback exceeds selected threshold
// - code 0..7 picks 105 to 125 percent
// - threshold register resets to 06h
// - overvoltage armed from soft-start onward
// - overvoltage sets sticky status, drives alert low
// - overvoltage protection on after reset, bit 7
// - threshold register one byte, bits 7:3 unused
// - masked fault takes no protective action
// - status bit stays set until cleared
module fault_response_ovp_config #(
    parameter int HICCUP_CYCLES = fault_resp_pkg::HICCUP_CYC
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // straps and enable
    input  wire logic        response_strap_pin,
    input  wire logic        enable_in,
    // management command port
    input  wire logic        cmd_wr,
    input  wire logic        cmd_rd,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    output logic      [15:0] cmd_rdata,
    output logic             cmd_rvalid,
    // fault detector levels
    input  wire logic        input_overvoltage_fault,
    input  wire logic        external_overtemp_fault,
    input  wire logic        average_overcurrent_fault,
    input  wire logic        phase_peak_overcurrent_fault,
    input  wire logic        output_undervoltage_fault,
    input  wire logic        loop_comp_short_fault,
    input  wire logic        pll_min_freq_fault,
    // feedback comparators, bit n above threshold n
    input  wire logic [7:0]  feedback_input,
    // fault mask and status clear
    input  wire logic [15:0] fault_mask,
    input  wire logic [15:0] status_clear,
    // status and power stage control
    output logic      [15:0] fault_status,
    output logic             alert_out_n,
    output logic             output_overvoltage_fault,
    output logic             switching_en,
    output logic             soft_start_go,
    output logic             latched_off
);

    // keep only the implemented reaction bits
    function automatic logic [15:0] clean_resp(input logic [15:0] v);
        clean_resp = v & fault_resp_pkg::REACTION_USED;
    endfunction : clean_resp

    localparam int CW = $clog2(HICCUP_CYCLES + 1);
    localparam logic [CW-1:0] HIC_LAST = CW'(HICCUP_CYCLES - 1);

    fault_resp_pkg::prot_state_t state_reg;
    fault_resp_pkg::prot_state_t state_next;
    logic [15:0]   react_reg;
    logic [2:0]    ovsel_reg;
    logic [15:0]   status_reg;
    logic [15:0]   status_next;
    logic [CW-1:0] hic_cnt_reg;
    logic [15:0]   rdata_reg;
    logic          rvalid_reg;
    logic          ov_reg;
    logic          sw_reg;
    logic          ss_reg;
    logic          en_prev_reg;
    logic          alert_reg;
    logic          latched_reg;

    wire logic        wr_react;
    wire logic        wr_ov;
    wire logic        ov_armed;
    wire logic        ov_raw;
    wire logic [15:0] raw_vec;
    wire logic [15:0] live_vec;
    wire logic        any_live;
    wire logic        any_latch;
    wire logic        hic_done;
    wire logic        en_fall;
    wire logic [15:0] rd_mux;
    wire logic [15:0] strap_val;

    // command decode
    assign wr_react = cmd_wr && (cmd_code == fault_resp_pkg::CMD_REACTION);
    assign wr_ov    = cmd_wr && (cmd_code == fault_resp_pkg::CMD_OV_THRESH);
    assign strap_val = response_strap_pin ? fault_resp_pkg::REACTION_ONES
                                          : fault_resp_pkg::REACTION_ZERO;

    // readback, unused bits zero
    assign rd_mux =
        (cmd_code == fault_resp_pkg::CMD_REACTION)  ? react_reg :
        (cmd_code == fault_resp_pkg::CMD_OV_THRESH) ? {13'h0000, ovsel_reg} :
        16'h0000;

    // overvoltage detect from soft-start onward
    assign ov_armed = sw_reg;
    assign ov_raw   = ov_armed && feedback_input[ovsel_reg];

    // fault vector, bits 2..9
    assign raw_vec = {6'h00,
                      pll_min_freq_fault,
                      loop_comp_short_fault,
                      ov_raw,
                      output_undervoltage_fault,
                      phase_peak_overcurrent_fault,
                      average_overcurrent_fault,
                      external_overtemp_fault,
                      input_overvoltage_fault,
                      2'b00};

    // unmasked faults cause action
    assign live_vec  = raw_vec & ~fault_mask;
    assign any_live  = |live_vec;
    assign any_latch = |(live_vec & ~react_reg);
    assign hic_done  = (hic_cnt_reg == HIC_LAST);
    assign en_fall   = en_prev_reg && !enable_in;

    // sticky status, set wins over clear
    assign status_next = (status_reg & ~status_clear) | raw_vec;

    // configuration registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            react_reg <= clean_resp(strap_val);
            ovsel_reg <= fault_resp_pkg::OV_RESET;
        end else begin
            if (wr_react) begin
                react_reg <= clean_resp(cmd_wdata);
            end
            if (wr_ov) begin
                ovsel_reg <= cmd_wdata[2:0];
            end
        end
    end

    // command readback, usable in every state
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_reg  <= 16'h0000;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= cmd_rd;
            if (cmd_rd) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // status and alert
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            status_reg <= 16'h0000;
            alert_reg  <= 1'b0;
            ov_reg     <= 1'b0;
        end else begin
            status_reg <= status_next;
            alert_reg  <= |status_next;
            ov_reg     <= ov_raw;
        end
    end

    // protection sequencer next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            fault_resp_pkg::ST_OFF: begin
                if (enable_in) begin
                    state_next = fault_resp_pkg::ST_RUN;
                end
            end
            fault_resp_pkg::ST_RUN: begin
                if (!enable_in) begin
                    state_next = fault_resp_pkg::ST_OFF;
                end else if (any_latch) begin
                    state_next = fault_resp_pkg::ST_LATCHED;
                end else if (any_live) begin
                    state_next = fault_resp_pkg::ST_HICCUP;
                end
            end
            fault_resp_pkg::ST_HICCUP: begin
                if (!enable_in) begin
                    state_next = fault_resp_pkg::ST_OFF;
                end else if (hic_done) begin
                    state_next = fault_resp_pkg::ST_RUN;
                end
            end
            fault_resp_pkg::ST_LATCHED: begin
                if (!enable_in) begin
                    state_next = fault_resp_pkg::ST_OFF;
                end
            end
            default: state_next = fault_resp_pkg::ST_OFF;
        endcase
    end

    // sequencer state, wait counter and stage control
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg   <= fault_resp_pkg::ST_OFF;
            hic_cnt_reg <= '0;
            sw_reg      <= 1'b0;
            ss_reg      <= 1'b0;
            en_prev_reg <= 1'b0;
            latched_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            latched_reg <= (state_next == fault_resp_pkg::ST_LATCHED);
            en_prev_reg <= enable_in;
            if (state_reg == fault_resp_pkg::ST_HICCUP) begin
                hic_cnt_reg <= hic_cnt_reg + 1'b1;
            end else begin
                hic_cnt_reg <= '0;
            end
            sw_reg <= (state_next == fault_resp_pkg::ST_RUN);
            ss_reg <= (state_next == fault_resp_pkg::ST_RUN)
                   && (state_reg != fault_resp_pkg::ST_RUN);
        end
    end

    // outputs straight from flops
    assign cmd_rdata                = rdata_reg;
    assign cmd_rvalid               = rvalid_reg;
    assign fault_status             = status_reg;
    assign alert_out_n              = !alert_reg;
    assign output_overvoltage_fault = ov_reg;
    assign switching_en             = sw_reg;
    assign soft_start_go            = ss_reg;
    assign latched_off              = latched_reg;

    // strap loads reaction bits at reset
    strap_load_a: assert property (@(posedge mclk)
        !rst_n |=> react_reg == ($past(response_strap_pin) ? 16'h03FF : 16'h0000))
        else $error("reaction register not loaded from strap");

    // upper reaction bits always zero
    react_unused_a: assert property (@(posedge mclk) disable iff (!rst_n)
        react_reg[15:10] == 6'h00)
        else $error("unused reaction bits set");

    // threshold reset value
    ov_reset_a: assert property (@(posedge mclk)
        !rst_n ##1 rst_n |-> ovsel_reg == 3'h6)
        else $error("threshold not reset to 06h");

    // readback of threshold hides bits 7:3
    ov_readback_a: assert property (@(posedge mclk) disable iff (!rst_n)
        cmd_rd && cmd_code == 8'hD3 |=> cmd_rdata[15:3] == 13'h0000)
        else $error("threshold upper bits read nonzero");

    // overvoltage sets status and alert next cycle
    ov_status_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ov_raw |=> fault_status[7] && !alert_out_n)
        else $error("overvoltage did not set status and alert");

    // status bit holds without clear
    status_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
        fault_status[7] && !status_clear[7] |=> fault_status[7])
        else $error("status bit dropped without clear");

    // latch-off holds until enable drops
    latch_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        latched_off && enable_in |=> latched_off && !switching_en)
        else $error("left latch-off without enable toggle");

    // enable drop releases latch
    latch_exit_a: assert property (@(posedge mclk) disable iff (!rst_n)
        latched_off && !enable_in |=> !latched_off)
        else $error("enable drop did not release latch");

    // hiccup fault stops switching
    hiccup_entry_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == fault_resp_pkg::ST_RUN && enable_in && any_live && !any_latch
        |=> state_reg == fault_resp_pkg::ST_HICCUP && !switching_en)
        else $error("hiccup not entered");

    // masked faults never stop switching
    mask_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
        switching_en && enable_in && !any_live |=> switching_en)
        else $error("switching stopped with only masked faults");

    // hiccup wait ends with soft-start
    hiccup_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == fault_resp_pkg::ST_HICCUP && hic_done && enable_in
        |=> soft_start_go && switching_en)
        else $error("hiccup did not restart soft-start");

    // readback answers in any state
    read_alive_a: assert property (@(posedge mclk) disable iff (!rst_n)
        cmd_rd |=> cmd_rvalid)
        else $error("read not answered");

    // enable drop turns the stage off
    enable_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        en_fall |=> !switching_en && !latched_off)
        else $error("enable drop did not stop switching");

    // soft-start request is a single pulse
    ss_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
        soft_start_go |=> !soft_start_go)
        else $error("soft-start pulse longer than one cycle");

    // latch-off fault stops switching
    latch_entry_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == fault_resp_pkg::ST_RUN && enable_in && any_latch
        |=> latched_off && !switching_en)
        else $error("latch-off not entered");

    // reaction write lands, unused bits dropped
    react_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_react |=> react_reg == ($past(cmd_wdata) & 16'h03FF))
        else $error("reaction write not stored");

    // threshold write keeps bits 2:0 only
    ov_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_ov |=> ovsel_reg == $past(cmd_wdata[2:0]))
        else $error("threshold write not stored");

    // detected overvoltage shown next cycle
    ov_output_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ov_raw |=> output_overvoltage_fault)
        else $error("overvoltage output not raised");

    // alert low exactly while status is set
    alert_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
        alert_out_n == (fault_status == 16'h0000))
        else $error("alert does not follow status");

endmodule : fault_response_ovp_config

//--- verif/host_model.sv
// host model for the command port, with enable control
`timescale 1ns/100ps
module host_model (
    // clock
    input  wire logic        mclk,
    // command port
    output logic             cmd_wr,
    output logic             cmd_rd,
    output logic      [7:0]  cmd_code,
    output logic      [15:0] cmd_wdata,
    input  wire logic [15:0] cmd_rdata,
    input  wire logic        cmd_rvalid,
    // enable control
    output logic             enable_in
);
    // idle values at time zero
    initial begin
        cmd_wr    = 1'b0;
        cmd_rd    = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
        enable_in = 1'b1;
    end
    // one write strobe, idle lines scrambled after
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        @(negedge mclk);
        cmd_code  = code;
        cmd_wdata = data;
        cmd_wr    = 1'b1;
        @(negedge mclk);
        cmd_wr    = 1'b0;
        cmd_code  = ~code;
        cmd_wdata = ~data;
    endtask : wr
    // one read strobe, bounded wait for the answer
    task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic ok);
        int i;
        ok   = 1'b0;
        data = 16'h0000;
        @(negedge mclk);
        cmd_code = code;
        cmd_rd   = 1'b1;
        @(negedge mclk);
        cmd_rd   = 1'b0;
        cmd_code = ~code;
        for (i = 0; i < 4 && ok == 1'b0; i++) begin
            if (cmd_rvalid === 1'b1) begin
                data = cmd_rdata;
                ok   = 1'b1;
            end else begin
                @(negedge mclk);
            end
        end
    endtask : rd
    // enable low then high to leave latch-off
    task automatic toggle_enable;
        @(negedge mclk);
        enable_in = 1'b0;
        @(negedge mclk);
        enable_in = 1'b1;
    endtask : toggle_enable
endmodule : host_model

//--- verif/fault_response_ovp_config_tb.sv
// self-checking bench for the fault reaction block
`timescale 1ns/100ps
module fault_response_ovp_config_tb;
    localparam int HIC = 8;
    logic        mclk, rst_n, strap, cmd_wr, cmd_rd, cmd_rvalid, enable_in;
    logic        alert_out_n, ov_flt, switching_en, soft_start_go, latched_off;
    logic [7:0]  cmd_code, feedback;
    logic [15:0] cmd_wdata, cmd_rdata, fault_mask, status_clear, fault_status;
    logic [6:0]  flt;
    int          miscompares = 0;
    int          check_count = 0;
    int          sb[7] = '{2, 3, 4, 5, 6, 8, 9};
    // clock source
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    host_model host (.mclk(mclk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
        .enable_in(enable_in));
    fault_response_ovp_config #(.HICCUP_CYCLES(HIC)) DUT (.mclk(mclk), .rst_n(rst_n),
        .response_strap_pin(strap), .enable_in(enable_in), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
        .input_overvoltage_fault(flt[0]), .external_overtemp_fault(flt[1]),
        .average_overcurrent_fault(flt[2]), .phase_peak_overcurrent_fault(flt[3]),
        .output_undervoltage_fault(flt[4]), .loop_comp_short_fault(flt[5]),
        .pll_min_freq_fault(flt[6]), .feedback_input(feedback),
        .fault_mask(fault_mask), .status_clear(status_clear),
        .fault_status(fault_status), .alert_out_n(alert_out_n),
        .output_overvoltage_fault(ov_flt), .switching_en(switching_en),
        .soft_start_go(soft_start_go), .latched_off(latched_off));
    // verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    task automatic chk16(string n, logic [15:0] e, logic [15:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk16
    task automatic chk1(string n, logic e, logic g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", n, e, g);
        end
    endtask : chk1
    task automatic cyc(int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task automatic rchk(string n, logic [7:0] code, logic [15:0] e);
        logic [15:0] d;
        logic        ok;
        host.rd(code, d, ok);
        if (ok !== 1'b1) begin
            miscompares++;
            test_done();
        end else begin
            chk16(n, e, d);
        end
    endtask : rchk
    // reset held five cycles with the given strap level
    task automatic do_reset(logic s);
        strap = s;
        rst_n = 1'b0;
        cyc(5);
        rst_n = 1'b1;
        cyc(3);
    endtask : do_reset
    // bounded wait for switching to resume, then clear status
    task automatic wait_on(logic ss);
        int i;
        for (i = 0; i < HIC + 8 && switching_en !== 1'b1; i++) cyc(1);
        if (switching_en !== 1'b1) begin
            miscompares++;
            test_done();
        end else begin
            chk1("soft_start_go", ss, soft_start_go);
            status_clear = 16'hFFFF;
            cyc(1);
            status_clear = 16'h0000;
            cyc(1);
            chk1("alert_out_n", 1'b1, alert_out_n);
        end
    endtask : wait_on
    // main sequence
    initial begin
        int k;
        rst_n = 1'b0; strap = 1'b1; flt = '0; feedback = 8'h00;
        fault_mask = 16'h0000; status_clear = 16'h0000;
        do_reset(1'b1);
        rchk("reaction", fault_resp_pkg::CMD_REACTION, 16'h03FF);
        rchk("threshold", fault_resp_pkg::CMD_OV_THRESH, 16'h0006);
        host.wr(fault_resp_pkg::CMD_REACTION, 16'hFFFF);
        rchk("reaction", fault_resp_pkg::CMD_REACTION, 16'h03FF);
        host.wr(fault_resp_pkg::CMD_OV_THRESH, 16'h00FF);
        rchk("threshold", fault_resp_pkg::CMD_OV_THRESH, 16'h0007);
        rchk("unmapped", 8'h55, 16'h0000);
        for (k = 0; k < 7; k++) begin
            flt[k] = 1'b1;
            cyc(1);
            flt[k] = 1'b0;
            cyc(1);
            chk1("switching_en", 1'b0, switching_en);
            chk1("status", 1'b1, fault_status[sb[k]]);
            chk1("alert_out_n", 1'b0, alert_out_n);
            wait_on(1'b1);
        end
        for (k = 0; k < 8; k++) begin
            host.wr(fault_resp_pkg::CMD_OV_THRESH, 16'(k));
            feedback = 8'((8'h01 << k) - 1);
            cyc(3);
            chk1("switching_en", 1'b1, switching_en);
            chk1("ov_flt", 1'b0, ov_flt);
            feedback = 8'((8'h02 << k) - 1);
            cyc(1);
            chk1("ov_flt", 1'b1, ov_flt);
            cyc(1);
            chk1("ov status", 1'b1, fault_status[7]);
            chk1("switching_en", 1'b0, switching_en);
            chk1("alert_out_n", 1'b0, alert_out_n);
            feedback = 8'h00;
            wait_on(1'b1);
        end
        fault_mask = 16'h0010;
        flt[2] = 1'b1;
        cyc(3);
        chk1("switching_en", 1'b1, switching_en);
        chk1("status", 1'b1, fault_status[4]);
        flt[2] = 1'b0;
        fault_mask = 16'h0000;
        wait_on(1'b0);
        host.wr(fault_resp_pkg::CMD_REACTION, 16'h0000);
        flt[1] = 1'b1;
        cyc(1);
        flt[1] = 1'b0;
        cyc(1);
        chk1("latched_off", 1'b1, latched_off);
        cyc(HIC + 6);
        chk1("switching_en", 1'b0, switching_en);
        rchk("threshold", fault_resp_pkg::CMD_OV_THRESH, 16'h0007);
        host.toggle_enable();
        wait_on(1'b1);
        chk1("latched_off", 1'b0, latched_off);
        do_reset(1'b0);
        rchk("reaction", fault_resp_pkg::CMD_REACTION, 16'h0000);
        test_done();
    end
endmodule : fault_response_ovp_config_tb
